// ### core/sqc_device.sv
// Device end: command interpreter for tag, count, status and tone commands
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "sqc_defines.svh"
module sqc_device (
  input wire logic clk,
  input wire logic nrst,
  sqc_link_if.dev lnk,
  input wire logic msg_we,
  input wire logic [`SQC_IDXW-1:0] msg_idx,
  input wire sqc_pkg::sqc_word_t msg_tag,
  input wire logic msg_present,
  input wire logic [`SQC_IDXW-1:0] cur_msg_idx,
  input wire logic cur_msg_defined,
  input wire logic [3:0] dual_tone_digit_code,
  input wire logic dual_tone_ended,
  input wire logic dual_tone_started,
  input wire logic operation_done,
  input wire logic storage_full,
  input wire logic storage_low,
  input wire logic command_fault,
  input wire logic busy_tone_seen,
  input wire logic dial_tone_seen,
  input wire logic steady_energy_seen,
  input wire logic silence_seen,
  input wire logic powerup_event,
  input wire logic init_clear,
  output logic tone_on,
  output logic tone_dual,
  output logic [3:0] tone_code,
  output sqc_pkg::sqc_byte_t tone_byte,
  output logic invalid_ctx,
  output sqc_pkg::sqc_word_t event_status_word
);
  import sqc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  sqc_dev_state_t state_r, state_nxt;
  sqc_byte_t op_r;
  logic [2:0] idx_r, len_r;
  sqc_word_t tag_mem [0:`SQC_NMSG-1];
  logic [`SQC_NMSG-1:0] present_r;
  sqc_word_t ref_r, mask_r, count_r, snap_r, status_r, status_nxt;
  logic [7:0] reply_r;
  logic reply_stb_r;
  logic req_n_r, pup_r;
  logic tone_on_r, invalid_r;
  sqc_byte_t tone_byte_r;
  // Tag captured at the opcode so a later change cannot tear the pair
  sqc_word_t tag_hold_r;

  ////////////////////////////////////////////////////////////////////////////
  // Byte decode
  wire take = lnk.h2d_stb;
  wire [7:0] din = lnk.h2d_data;
  wire at_op = take && (state_r == SQC_ST_IDLE);
  wire in_body = take && (state_r == SQC_ST_BODY);
  wire last_byte = in_body && (idx_r == len_r - 3'h1);
  wire op_tag = at_op && (din == `SQC_OP_GET_TAG);
  wire op_cnt = at_op && (din == `SQC_OP_COUNT);
  wire op_evt = at_op && (din == `SQC_OP_EVENTS);
  wire op_tone = at_op && (din == `SQC_OP_TONE);
  wire op_stop = at_op && (din == `SQC_OP_STOP);
  wire [2:0] len_new = (din == `SQC_OP_GET_TAG) ? `SQC_LEN_GET_TAG :
    (din == `SQC_OP_COUNT) ? `SQC_LEN_COUNT :
    (din == `SQC_OP_EVENTS) ? `SQC_LEN_EVENTS :
    (din == `SQC_OP_TONE) ? `SQC_LEN_TONE : `SQC_LEN_OTHER;
  wire evt_done = last_byte && (op_r == `SQC_OP_EVENTS);
  wire tone_param = in_body && (op_r == `SQC_OP_TONE);
  wire cnt_final = in_body && (op_r == `SQC_OP_COUNT) && (idx_r == 3'h4);
  // [RL2] invalid context check
  wire tag_invalid = op_tag && !cur_msg_defined;
  // [RL1] current tag lookup
  wire [15:0] cur_tag = cur_msg_defined ? tag_mem[cur_msg_idx] : 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Per-entry match; mask low byte arrives with the final parameter
  wire [15:0] mask_full = {mask_r[15:8], din};
  logic [`SQC_NMSG-1:0] match;
  genvar gi;
  generate
    for (gi = 0; gi < `SQC_NMSG; gi++) begin : g_match
      // [RL3] masked compare
      // [RL5] zero mask matches every present entry
      assign match[gi] = present_r[gi] &&
        ((tag_mem[gi] & mask_full) == (ref_r & mask_full));
    end
  endgenerate

  function automatic sqc_word_t count_ones(input logic [`SQC_NMSG-1:0] v);
    sqc_word_t n;
    n = 16'h0000;
    for (int i = 0; i < `SQC_NMSG; i++) begin
      n = n + {15'h0000, v[i]};
    end
    return n;
  endfunction

  wire sqc_word_t match_count = count_ones(match);

  ////////////////////////////////////////////////////////////////////////////
  // Reply byte: echo opcode and parameters, then answer MSB first
  logic [7:0] reply_nxt;
  always_comb begin
    reply_nxt = din;
    if (in_body) begin
      case (op_r)
        // [RL1] tag high then low
        `SQC_OP_GET_TAG: reply_nxt = (idx_r == 3'h1) ? tag_hold_r[15:8] : tag_hold_r[7:0];
        // [RL4] count after four echoed parameters
        `SQC_OP_COUNT: begin
          if (idx_r == 3'h5) begin
            reply_nxt = count_r[15:8];
          end else if (idx_r == 3'h6) begin
            reply_nxt = count_r[7:0];
          end else begin
            reply_nxt = din;
          end
        end
        // [RL6] status word high then low
        `SQC_OP_EVENTS: reply_nxt = (idx_r == 3'h1) ? snap_r[15:8] : snap_r[7:0];
        default: reply_nxt = din;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event vector into the status word
  logic [15:0] ev;
  always_comb begin
    ev = 16'h0000;
    // [RL9] tone ended flag
    ev[`SQC_BIT_ENDED] = dual_tone_ended;
    // [RL11] normal end
    ev[`SQC_BIT_DONE] = operation_done;
    // [RL12] storage flags
    ev[`SQC_BIT_FULL] = storage_full;
    ev[`SQC_BIT_LOW] = storage_low;
    // [RL13] command fault, own or external
    ev[`SQC_BIT_FAULT] = command_fault || tag_invalid;
    // [RL15] call progress tones
    ev[`SQC_BIT_BUSY] = busy_tone_seen;
    ev[`SQC_BIT_DIAL] = dial_tone_seen;
    // [RL16] energy and silence
    ev[`SQC_BIT_ENERGY] = steady_energy_seen;
    ev[`SQC_BIT_SILENCE] = silence_seen;
    // [RL17] power-up or internal fault
    ev[`SQC_BIT_POWERUP] = pup_r || powerup_event;
    // [RL10] tone start
    ev[`SQC_BIT_STARTED] = dual_tone_started;
  end

  // Set wins over every clear; the digit field takes the newest code
  always_comb begin
    status_nxt = status_r;
    // [RL8] clear after completed read
    // [RL22] only the bits already reported
    if (evt_done) begin
      status_nxt = status_r & ~snap_r;
    end
    if (init_clear) begin
      status_nxt[`SQC_BIT_POWERUP] = 1'b0;
    end
    status_nxt = status_nxt | ev;
    // [RL9] digit code field
    if (dual_tone_ended) begin
      status_nxt[3:0] = dual_tone_digit_code;
    end
    // [RL16] reserved bit stays zero
    status_nxt[`SQC_BIT_RES] = 1'b0;
  end

  // [RL7] request line: any event lowers it, read opcode raises it
  wire req_low = (|ev) || (evt_done && (|status_nxt));
  wire req_n_nxt = req_low ? 1'b0 : (op_evt ? 1'b1 : req_n_r);

  always_comb begin
    state_nxt = state_r;
    if (at_op && (len_new != `SQC_LEN_OTHER)) begin
      state_nxt = SQC_ST_BODY;
    end else if (last_byte) begin
      state_nxt = SQC_ST_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= SQC_ST_IDLE;
      op_r <= 8'h00;
      idx_r <= 3'h0;
      len_r <= 3'h1;
      reply_r <= 8'h00;
      reply_stb_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      reply_stb_r <= take;
      if (take) begin
        // [RL21] one reply byte per host byte
        reply_r <= reply_nxt;
      end
      if (at_op) begin
        op_r <= din;
        len_r <= len_new;
        idx_r <= 3'h1;
      end else if (in_body) begin
        idx_r <= idx_r + 3'h1;
      end
    end
  end

  // Parameters, snapshots and count
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ref_r <= 16'h0000;
      mask_r <= 16'h0000;
      count_r <= 16'h0000;
      snap_r <= 16'h0000;
      tag_hold_r <= 16'h0000;
    end else begin
      if (in_body && (op_r == `SQC_OP_COUNT)) begin
        case (idx_r)
          3'h1: ref_r[15:8] <= din;
          3'h2: ref_r[7:0] <= din;
          3'h3: mask_r[15:8] <= din;
          3'h4: mask_r[7:0] <= din;
          default: ref_r <= ref_r;
        endcase
      end
      // [RL3] count latched with last parameter
      if (cnt_final) begin
        count_r <= match_count;
      end
      // [RL6] snapshot at opcode
      if (op_evt) begin
        snap_r <= status_r;
      end
      if (op_tag) begin
        tag_hold_r <= cur_tag;
      end
    end
  end

  // Message tag store loaded from the user side
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      present_r <= '0;
    end else if (msg_we) begin
      present_r[msg_idx] <= msg_present;
    end
  end

  always_ff @(posedge clk) begin
    if (msg_we) begin
      tag_mem[msg_idx] <= msg_tag;
    end
  end

  // Status word and request line
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // [RL8] reset clears status
      status_r <= `SQC_STATUS_RESET;
      req_n_r <= 1'b1;
      pup_r <= 1'b1;
      invalid_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      req_n_r <= req_n_nxt;
      pup_r <= 1'b0;
      // [RL2] fault pulse for the error word
      invalid_r <= tag_invalid;
    end
  end

  // Tone generator control
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tone_on_r <= 1'b0;
      tone_byte_r <= 8'h00;
    end else begin
      // [RL19] run until stop
      if (tone_param) begin
        tone_on_r <= 1'b1;
        tone_byte_r <= din;
      end else if (op_stop) begin
        tone_on_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops
  assign lnk.d2h_data = reply_r;
  assign lnk.d2h_stb = reply_stb_r;
  assign lnk.host_request_n = req_n_r;
  assign tone_on = tone_on_r;
  // [RL20] dual tone select and code
  assign tone_dual = tone_byte_r[`SQC_TONE_DUAL_BIT];
  assign tone_code = tone_byte_r[4:1];
  assign tone_byte = tone_byte_r;
  assign invalid_ctx = invalid_r;
  assign event_status_word = status_r;
endmodule // sqc_device

// ### common/sqc_defines.svh
// Constants for the status, tag and tone command slice of the speech processor
// Operation
// [RL1] Get-tag returns current tag, two bytes
// [RL2] Undefined current message raises invalid-context fault
// [RL3] Count when tag AND mask equals ref AND mask
// [RL4] Count command: ref, mask in; count out
// [RL5] Zero mask counts every stored message
// [RL6] Read-events returns 16-bit status, two bytes
// [RL7] Status change pulls request low until read
// [RL8] Status cleared at reset and after read
// [RL9] Bits 3..0 digit, bit 4 tone ended
// [RL10] Bit 15 set when tone detection starts
// [RL11] Bit 5 set on normal operation end
// [RL12] Bit 6 storage full, bit 10 low
// [RL13] Bit 7 set on command fault
// [RL14] Host reads fault word after fault flag
// [RL15] Bit 8 busy tone, bit 9 dial
// [RL16] Bit 12 energy, 13 silence, 11 reserved
// [RL17] Power-up sets bit 14, asserts request
// [RL18] Host reinitialises on unexpected bit 14
// [RL19] Tone command takes byte, runs until stop
// [RL20] Tone bit 0 selects dual tone, code
// [RL21] Host sends fillers; device echoes, MSB first
// [RL22] Events during status readout are kept
`ifndef SQC_DEFINES_SVH
`define SQC_DEFINES_SVH
`define SQC_OP_GET_TAG 8'h04
`define SQC_OP_COUNT 8'h11
`define SQC_OP_EVENTS 8'h14
`define SQC_OP_TONE 8'h0D
`define SQC_OP_STOP 8'h3F
`define SQC_FILLER 8'hAA
`define SQC_LEN_GET_TAG 3'h3
`define SQC_LEN_COUNT 3'h7
`define SQC_LEN_EVENTS 3'h3
`define SQC_LEN_TONE 3'h2
`define SQC_LEN_OTHER 3'h1
`define SQC_NMSG 8
`define SQC_IDXW 3
`define SQC_BIT_DONE 5
`define SQC_BIT_FULL 6
`define SQC_BIT_FAULT 7
`define SQC_BIT_BUSY 8
`define SQC_BIT_DIAL 9
`define SQC_BIT_LOW 10
`define SQC_BIT_RES 11
`define SQC_BIT_ENERGY 12
`define SQC_BIT_SILENCE 13
`define SQC_BIT_POWERUP 14
`define SQC_BIT_STARTED 15
`define SQC_BIT_ENDED 4
`define SQC_STATUS_RESET 16'h0000
`define SQC_TONE_DUAL_BIT 0
`endif

// ### common/sqc_pkg.sv
// Types shared by both ends of the command link
package sqc_pkg;
  typedef enum logic {SQC_ST_IDLE, SQC_ST_BODY} sqc_dev_state_t;
  typedef enum logic [1:0] {SQC_H_IDLE, SQC_H_SEND, SQC_H_WAIT} sqc_host_state_t;
  typedef logic [7:0] sqc_byte_t;
  typedef logic [15:0] sqc_word_t;
endpackage

// ### common/sqc_link_if.sv
// Byte command link between host controller and speech processor
`timescale 1ns/1ps
interface sqc_link_if;
  logic [7:0] h2d_data;
  logic h2d_stb;
  logic [7:0] d2h_data;
  logic d2h_stb;
  logic host_request_n;
  modport dev (input h2d_data, input h2d_stb, output d2h_data, output d2h_stb,
    output host_request_n);
  modport host (output h2d_data, output h2d_stb, input d2h_data, input d2h_stb,
    input host_request_n);
endinterface

// ### core/sqc_host.sv
// Host end: sends a command byte by byte and gathers the answer
`timescale 1ns/1ps
`include "sqc_defines.svh"
module sqc_host (
  input wire logic clk,
  input wire logic nrst,
  sqc_link_if.host lnk,
  input wire logic cmd_start,
  input wire sqc_pkg::sqc_byte_t cmd_op,
  input wire sqc_pkg::sqc_word_t cmd_p0,
  input wire sqc_pkg::sqc_word_t cmd_p1,
  input wire logic [2:0] cmd_nparam,
  input wire logic [1:0] cmd_nresp,
  output logic cmd_busy,
  output logic cmd_done,
  output sqc_pkg::sqc_word_t cmd_resp,
  output logic events_pending
);
  import sqc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  sqc_host_state_t state_r, state_nxt;
  logic [2:0] pos_r, total_r, npar_r;
  sqc_word_t p0_r, p1_r, resp_r;
  sqc_byte_t op_r, out_r;
  logic stb_r, done_r, pend_r;

  // Byte for position: opcode, params high first, then fillers
  logic [7:0] byte_sel;
  always_comb begin
    case (pos_r)
      3'h0: byte_sel = op_r;
      3'h1: byte_sel = (npar_r == 3'h1) ? p0_r[7:0] : p0_r[15:8];
      3'h2: byte_sel = p0_r[7:0];
      3'h3: byte_sel = p1_r[15:8];
      3'h4: byte_sel = p1_r[7:0];
      default: byte_sel = `SQC_FILLER;
    endcase
    // [RL21] fillers after parameters
    if (pos_r > npar_r) begin
      byte_sel = `SQC_FILLER;
    end
  end

  wire got = (state_r == SQC_H_WAIT) && lnk.d2h_stb;
  wire last = (pos_r == total_r - 3'h1);
  // [RL21] answer bytes arrive MSB first
  wire is_resp = pos_r > npar_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SQC_H_IDLE: state_nxt = cmd_start ? SQC_H_SEND : SQC_H_IDLE;
      SQC_H_SEND: state_nxt = SQC_H_WAIT;
      SQC_H_WAIT: state_nxt = got ? (last ? SQC_H_IDLE : SQC_H_SEND) : SQC_H_WAIT;
      default: state_nxt = SQC_H_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer; one byte in flight, next sent only after its echo
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= SQC_H_IDLE;
      pos_r <= 3'h0;
      total_r <= 3'h1;
      npar_r <= 3'h0;
      op_r <= 8'h00;
      p0_r <= 16'h0000;
      p1_r <= 16'h0000;
      out_r <= 8'h00;
      stb_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      stb_r <= (state_r == SQC_H_SEND);
      if (state_r == SQC_H_SEND) begin
        out_r <= byte_sel;
      end
      if ((state_r == SQC_H_IDLE) && cmd_start) begin
        op_r <= cmd_op;
        p0_r <= cmd_p0;
        p1_r <= cmd_p1;
        npar_r <= cmd_nparam;
        // [RL4] total bytes in the exchange
        total_r <= 3'h1 + cmd_nparam + {1'b0, cmd_nresp};
        pos_r <= 3'h0;
      end else if (got) begin
        pos_r <= pos_r + 3'h1;
      end
    end
  end

  // Answer, completion and request tracking
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      resp_r <= 16'h0000;
      done_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      done_r <= got && last;
      if ((state_r == SQC_H_IDLE) && cmd_start) begin
        resp_r <= 16'h0000;
      end else if (got && is_resp) begin
        resp_r <= {resp_r[7:0], lnk.d2h_data};
      end
      // [RL14] request line shown for the user to read events, then fault word
      // [RL18] unexpected power-up bit is the user's cue to reinitialise
      pend_r <= !lnk.host_request_n;
    end
  end

  assign lnk.h2d_data = out_r;
  assign lnk.h2d_stb = stb_r;
  assign cmd_busy = (state_r != SQC_H_IDLE);
  assign cmd_done = done_r;
  assign cmd_resp = resp_r;
  assign events_pending = pend_r;
endmodule // sqc_host

// ### tb/sqc_link_sva.sv
// Concurrent checks on the byte link joining host and device ends
`timescale 1ns/1ps
`include "sqc_defines.svh"
module sqc_link_sva (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] h2d_data,
  input wire logic h2d_stb,
  input wire logic [7:0] d2h_data,
  input wire logic d2h_stb,
  input wire logic host_request_n
);
  import sqc_pkg::*;
  logic [2:0] rem_r;
  logic [2:0] rem_nxt;
  sqc_byte_t op_r;
  sqc_byte_t op_nxt;
  wire logic [2:0] cmd_len;
  wire logic op_stb;
  wire logic par_stb;
  wire logic fill_stb;
  wire logic ev_op;
  ////////////////////////////////////////////////////////////////////////////////
  // Byte position tracking; unknown opcodes count as one-byte commands
  assign op_stb = h2d_stb && (rem_r == 3'h0);
  assign cmd_len = (h2d_data == `SQC_OP_GET_TAG) ? `SQC_LEN_GET_TAG :
    (h2d_data == `SQC_OP_COUNT) ? `SQC_LEN_COUNT :
    (h2d_data == `SQC_OP_EVENTS) ? `SQC_LEN_EVENTS :
    (h2d_data == `SQC_OP_TONE) ? `SQC_LEN_TONE : `SQC_LEN_OTHER;
  assign rem_nxt = op_stb ? cmd_len - 3'h1 : (h2d_stb ? rem_r - 3'h1 : rem_r);
  assign op_nxt = op_stb ? h2d_data : op_r;
  assign par_stb = h2d_stb && !op_stb && ((op_r == `SQC_OP_COUNT && rem_r > 3'h2) ||
    op_r == `SQC_OP_TONE);
  assign fill_stb = h2d_stb && !op_stb && rem_r <= 3'h2 && op_r != `SQC_OP_TONE;
  assign ev_op = op_stb && (h2d_data == `SQC_OP_EVENTS);
  // Position registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rem_r <= 3'h0;
      op_r <= 8'h00;
    end else begin
      rem_r <= rem_nxt;
      op_r <= op_nxt;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_reply_next;
    h2d_stb |=> d2h_stb;
  endproperty
  a_reply_next: assert property (p_reply_next) else $error("no reply byte");
  property p_no_spurious;
    !h2d_stb |=> !d2h_stb;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("stray reply");
  property p_echo_op;
    op_stb |=> d2h_data == $past(h2d_data);
  endproperty
  a_echo_op: assert property (p_echo_op) else $error("opcode not echoed");
  property p_echo_param;
    par_stb |=> d2h_data == $past(h2d_data);
  endproperty
  a_echo_param: assert property (p_echo_param) else $error("param not echoed");
  property p_filler;
    fill_stb |-> h2d_data == `SQC_FILLER;
  endproperty
  a_filler: assert property (p_filler) else $error("bad filler byte");
  property p_host_spacing;
    h2d_stb |=> !h2d_stb [*2];
  endproperty
  a_host_spacing: assert property (p_host_spacing) else $error("host too fast");
  property p_req_release;
    $rose(host_request_n) |-> $past(ev_op, 1) || $past(ev_op, 2);
  endproperty
  a_req_release: assert property (p_req_release) else $error("request dropped");
  property p_req_hold;
    !host_request_n && !ev_op |=> !host_request_n;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request not held");
  property p_powerup;
    $rose(nrst) |-> ##[1:3] !host_request_n;
  endproperty
  a_powerup: assert property (p_powerup) else $error("no power-up request");
  c_events: cover property (ev_op);
  c_tone: cover property (op_stb && h2d_data == `SQC_OP_TONE);
  c_count: cover property (op_stb && h2d_data == `SQC_OP_COUNT);
  c_release: cover property ($rose(host_request_n));
endmodule // sqc_link_sva

// ### tb/testbench.sv
// Self-checking bench for the host and device ends across one link
`timescale 1ns/1ps
`include "sqc_defines.svh"
module testbench;
  import sqc_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic msg_we = 1'b0;
  logic [2:0] msg_idx = 3'h0;
  sqc_word_t msg_tag = 16'h0000;
  logic msg_present = 1'b0;
  logic [2:0] cur_idx = 3'h0;
  logic cur_def = 1'b0;
  logic [3:0] digit = 4'h0;
  logic [10:0] ev_r = 11'h000;
  logic init_clear = 1'b0;
  logic tone_on, tone_dual, invalid_ctx, cmd_busy, cmd_done, events_pending;
  logic [3:0] tone_code;
  sqc_byte_t tone_byte;
  sqc_word_t status_w, cmd_resp;
  logic cmd_start = 1'b0;
  sqc_byte_t cmd_op = 8'h00;
  sqc_word_t cmd_p0 = 16'h0000;
  sqc_word_t cmd_p1 = 16'h0000;
  logic [2:0] cmd_np = 3'h0;
  logic [1:0] cmd_nr = 2'h0;
  logic [16:0] q[$];
  sqc_word_t tags[8];
  logic pres[8];
  logic [15:0] seed = 16'h004E;
  logic inv_seen = 1'b0;
  int fail_count = 0;
  int total_checks = 0;
  int ev_pos[11] = '{4, 15, 5, 6, 10, 7, 8, 9, 12, 13, 14};
  sqc_word_t rf[3];
  sqc_word_t mk[3];
  sqc_byte_t b;
  sqc_word_t ex;
  ////////////////////////////////////////////////////////////////////////////////
  sqc_link_if lnk();
  sqc_device u_sqc_device (.clk(clk), .nrst(nrst), .lnk(lnk), .msg_we(msg_we),
    .msg_idx(msg_idx), .msg_tag(msg_tag), .msg_present(msg_present), .cur_msg_idx(cur_idx),
    .cur_msg_defined(cur_def), .dual_tone_digit_code(digit), .dual_tone_ended(ev_r[0]),
    .dual_tone_started(ev_r[1]), .operation_done(ev_r[2]), .storage_full(ev_r[3]),
    .storage_low(ev_r[4]), .command_fault(ev_r[5]), .busy_tone_seen(ev_r[6]),
    .dial_tone_seen(ev_r[7]), .steady_energy_seen(ev_r[8]), .silence_seen(ev_r[9]),
    .powerup_event(ev_r[10]), .init_clear(init_clear), .tone_on(tone_on),
    .tone_dual(tone_dual), .tone_code(tone_code), .tone_byte(tone_byte),
    .invalid_ctx(invalid_ctx), .event_status_word(status_w));
  sqc_host u_sqc_host (.clk(clk), .nrst(nrst), .lnk(lnk), .cmd_start(cmd_start),
    .cmd_op(cmd_op), .cmd_p0(cmd_p0), .cmd_p1(cmd_p1), .cmd_nparam(cmd_np),
    .cmd_nresp(cmd_nr), .cmd_busy(cmd_busy), .cmd_done(cmd_done), .cmd_resp(cmd_resp),
    .events_pending(events_pending));
  sqc_link_sva u_sqc_link_sva (.clk(clk), .nrst(nrst), .h2d_data(lnk.h2d_data),
    .h2d_stb(lnk.h2d_stb), .d2h_data(lnk.d2h_data), .d2h_stb(lnk.d2h_stb),
    .host_request_n(lnk.host_request_n));
  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  always #12.5 clk = ~clk;
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Only present entries take part in the masked match
  function automatic sqc_word_t count_of(input sqc_word_t r, input sqc_word_t m);
    sqc_word_t n;
    n = 16'h0000;
    for (int i = 0; i < 8; i++) n += (pres[i] && ((tags[i] & m) == (r & m))) ? 16'h1 : 16'h0;
    return n;
  endfunction
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  // Issue one command; the expected answer goes in the queue first
  task automatic run_cmd(input sqc_byte_t op, input sqc_word_t p0, input sqc_word_t p1,
    input logic [2:0] np, input logic [1:0] nr, input logic chk, input sqc_word_t e);
    int n;
    q.push_back({chk, e});
    @(posedge clk);
    cmd_start <= 1'b1;
    cmd_op <= op;
    cmd_p0 <= p0;
    cmd_p1 <= p1;
    cmd_np <= np;
    cmd_nr <= nr;
    @(posedge clk);
    cmd_start <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cmd_done !== 1'b1 && n < 200);
    check(n < 200, "command hung");
  endtask
  task automatic pulse_ev(input int i);
    @(posedge clk);
    ev_r <= 11'h001 << i;
    @(posedge clk);
    ev_r <= 11'h000;
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Scoreboard: oldest note against each finished answer
  always @(posedge clk) begin
    if (invalid_ctx === 1'b1) inv_seen = 1'b1;
    if (cmd_done === 1'b1) begin
      check(q.size() > 0, "unexpected done");
      if (q.size() > 0 && q[0][16]) check(cmd_resp === q[0][15:0], "answer differs");
      if (q.size() > 0) void'(q.pop_front());
    end
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    check(lnk.host_request_n === 1'b0 && events_pending === 1'b1, "no request");
    run_cmd(`SQC_OP_EVENTS, 0, 0, 3'h0, 2'h2, 1, 16'h4000);
    check(lnk.host_request_n === 1'b1 && status_w === 16'h0000 && cmd_busy === 1'b0,
      "request kept");
    // Each event sets its own bit only; tone end sets its bit and loads the digit field
    for (int i = 0; i < 11; i++) begin
      seed = lfsr_next(seed);
      @(posedge clk);
      digit <= seed[3:0];
      pulse_ev(i);
      repeat (3) @(posedge clk);
      check(lnk.host_request_n === 1'b0, "no request");
      ex = (16'h0001 << ev_pos[i]) | ((i == 0) ? {12'h000, seed[3:0]} : 16'h0000);
      run_cmd(`SQC_OP_EVENTS, 0, 0, 3'h0, 2'h2, 1, ex);
    end
    pulse_ev(10);
    @(posedge clk);
    init_clear <= 1'b1;
    @(posedge clk);
    init_clear <= 1'b0;
    run_cmd(`SQC_OP_EVENTS, 0, 0, 3'h0, 2'h2, 1, 16'h0000);
    // Event landing during readout survives the clear
    fork
      run_cmd(`SQC_OP_EVENTS, 0, 0, 3'h0, 2'h2, 0, 16'h0000);
      begin
        repeat (7) @(posedge clk);
        pulse_ev(2);
      end
    join
    run_cmd(`SQC_OP_EVENTS, 0, 0, 3'h0, 2'h2, 1, 16'h0020);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr_next(seed);
      tags[i] = seed;
      pres[i] = seed[0] | (i < 3);
      @(posedge clk);
      msg_we <= 1'b1;
      msg_idx <= 3'(i);
      msg_tag <= seed;
      msg_present <= pres[i];
    end
    @(posedge clk);
    msg_we <= 1'b0;
    cur_def <= 1'b1;
    cur_idx <= 3'h3;
    run_cmd(`SQC_OP_GET_TAG, 0, 0, 3'h0, 2'h2, 1, tags[3]);
    @(posedge clk);
    cur_def <= 1'b0;
    run_cmd(`SQC_OP_GET_TAG, 0, 0, 3'h0, 2'h2, 1, 16'h0000);
    check(inv_seen === 1'b1, "no context fault");
    run_cmd(`SQC_OP_EVENTS, 0, 0, 3'h0, 2'h2, 1, 16'h0080);
    rf = '{tags[2], seed, seed};
    mk = '{16'hFFFF, 16'h0003, 16'h0000};
    for (int i = 0; i < 3; i++) run_cmd(`SQC_OP_COUNT, rf[i], mk[i], 3'h4, 2'h2, 1,
      count_of(rf[i], mk[i]));
    // Dual tone codes 0 to 9, then one single-frequency byte
    for (int i = 0; i < 11; i++) begin
      b = (i == 10) ? 8'h20 : {3'h0, 4'(i), 1'b1};
      run_cmd(`SQC_OP_TONE, {8'h00, b}, 0, 3'h1, 2'h0, 0, 0);
      check(tone_on === 1'b1 && tone_byte === b, "tone not running");
      check(tone_dual === (i != 10) && (i == 10 || tone_code === 4'(i)), "tone code");
      run_cmd(`SQC_OP_STOP, 0, 0, 3'h0, 2'h0, 0, 0);
      check(tone_on === 1'b0, "tone not stopped");
    end
    end_of_test();
  end
endmodule // testbench
